// ==== hdl/stif_top.v ====
// Purpose: Serial terminal interface with independent receiver and transmitter sub-devices.
// Assumes: 125 MHz ref_clk_i; line-side signals synchronous to it; one-cycle bus strobes.
// Notes: Interrupt status bits 1:0 are the pending flags, bits 3:2 sticky completion events.
// Notes: A command written while its sub-device is busy is dropped whole, control word included.
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`include "stif_map.vh"

module stif_top #(
    parameter [15:0] CHAR_CYCLES = `STIF_CHAR_CYCLES
) (
    input wire ref_clk_i, // System clock.
    input wire rst_n_i, // Asynchronous reset, active low.
    input wire ce_i, // Clock enable, freezes state when low.
    input wire [7:0] addr_i, // Register byte address.
    input wire [31:0] wr_data_i, // Write data.
    input wire wr_i, // Write strobe.
    input wire rd_i, // Read strobe.
    output wire [31:0] rd_data_o, // Read data, cycle after rd_i.
    output wire irq_o, // Level interrupt.
    output wire [7:0] tx_data_o, // Character to the terminal.
    output wire tx_valid_o, // Character offered to the terminal.
    input wire tx_ready_i, // Terminal takes the character.
    input wire tx_err_i, // Terminal flags a send error with tx_ready_i.
    input wire [7:0] rx_data_i, // Character from the terminal.
    input wire rx_valid_i, // Terminal offers a character.
    input wire rx_err_i, // Terminal flags a receive error with rx_valid_i.
    output wire rx_ready_o // Receiver accepts a character.
);

    // Each sub-device walks IDLE, then XFER while the character is on the link, then PACE
    // until the character time is used up, so that back-to-back commands never beat the line rate.
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_XFER = 2'b01;
    localparam [1:0] ST_PACE = 2'b10;
    // One less than the character time, since the load cycle itself counts as the first.
    localparam [15:0] TMR_LOAD = CHAR_CYCLES - 16'h0001;

    reg rst_meta_reg;
    reg rst_q_reg;

    // Transmitter sub-device state.
    reg [1:0] tx_st_reg;
    reg [7:0] tx_code_reg;
    reg [7:0] tx_echo_char_field_reg;
    reg [31:0] tx_control_word_reg;
    reg [15:0] tx_tmr_reg;
    reg [7:0] tx_data_reg;
    reg tx_valid_reg;
    reg tx_bad_reg;
    reg tx_pend_reg;

    // Receiver sub-device state.
    reg [1:0] rx_st_reg;
    reg [7:0] rx_code_reg;
    reg [7:0] rx_char_field_reg;
    reg [31:0] rx_control_word_reg;
    reg [15:0] rx_tmr_reg;
    reg [7:0] rx_hold_reg;
    reg rx_ready_reg;
    reg rx_bad_reg;
    reg rx_pend_reg;

    // Interrupt side and registered read path.
    reg [1:0] evt_reg;
    reg [3:0] mask_reg;
    reg irq_reg;
    reg [31:0] rd_data_reg;
    reg [31:0] rd_data_next;
    reg [1:0] evt_next;
    reg [3:0] mask_next;
    reg irq_next;

    // The next code a command produces when the sub-device is idle.
    function [7:0] stif_cmd_code;
        input [7:0] op;
        begin
            case (op)
                `STIF_OP_RESET: stif_cmd_code = `STIF_CODE_READY;
                `STIF_OP_ACK: stif_cmd_code = `STIF_CODE_READY;
                `STIF_OP_MOVE: stif_cmd_code = `STIF_CODE_BUSY;
                default: stif_cmd_code = `STIF_CODE_ILLEGAL;
            endcase
        end
    endfunction

    // True for any operation code outside reset, acknowledge and move.
    function stif_is_illegal;
        input [7:0] op;
        begin
            stif_is_illegal = (op != `STIF_OP_RESET) && (op != `STIF_OP_ACK) && (op != `STIF_OP_MOVE);
        end
    endfunction

    // Saturating down-count, so an idle timer rests at zero.
    function [15:0] stif_dec;
        input [15:0] cnt;
        begin
            stif_dec = (cnt == 16'h0000) ? 16'h0000 : cnt - 16'h0001;
        end
    endfunction

    // Packs a code and its character into the layout software reads.
    function [31:0] stif_state_word;
        input [7:0] code;
        input [7:0] chr;
        begin
            stif_state_word = {16'h0000, chr, code};
        end
    endfunction

    // Address match of one register of the window.
    function stif_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            stif_hit = (addr == ofs);
        end
    endfunction

    // Completion code of a finished transfer.
    function [7:0] stif_done_code;
        input bad;
        begin
            stif_done_code = bad ? `STIF_CODE_ERROR : `STIF_CODE_DONE;
        end
    endfunction

    wire rst_q = rst_q_reg;
    // Operation and character fields of a command write.
    wire [7:0] wr_op = wr_data_i[`STIF_CODE_MSB:`STIF_CODE_LSB];
    wire [7:0] wr_char = wr_data_i[`STIF_CHAR_MSB:`STIF_CHAR_LSB];
    wire rx_wr = wr_i && stif_hit(addr_i, `STIF_RX_CTRL_OFS);
    wire tx_wr = wr_i && stif_hit(addr_i, `STIF_TX_CTRL_OFS);
    wire mask_wr = wr_i && stif_hit(addr_i, `STIF_INT_MASK_OFS);
    wire stat_rd = rd_i && stif_hit(addr_i, `STIF_INT_STAT_OFS);
    wire tx_idle = (tx_st_reg == ST_IDLE);
    wire rx_idle = (rx_st_reg == ST_IDLE);
    wire tx_start = tx_wr && tx_idle && (wr_op == `STIF_OP_MOVE);
    wire rx_start = rx_wr && rx_idle && (wr_op == `STIF_OP_MOVE);
    wire tx_take = (tx_st_reg == ST_XFER) && tx_ready_i;
    wire rx_take = (rx_st_reg == ST_XFER) && rx_valid_i;
    wire tx_fin = (tx_st_reg == ST_PACE) && (tx_tmr_reg == 16'h0000);
    wire rx_fin = (rx_st_reg == ST_PACE) && (rx_tmr_reg == 16'h0000);
    wire tx_ill = tx_wr && tx_idle && stif_is_illegal(wr_op);
    wire rx_ill = rx_wr && rx_idle && stif_is_illegal(wr_op);
    wire [1:0] evt_set = {(tx_fin | tx_ill), (rx_fin | rx_ill)};
    // Bits 3:2 are the sticky completion events, bits 1:0 the pending flags.
    wire [3:0] int_stat = {evt_reg, tx_pend_reg, rx_pend_reg};
    // The two state words as software sees them.
    wire [31:0] rx_state_word = stif_state_word(rx_code_reg, rx_char_field_reg);
    wire [31:0] tx_state_word = stif_state_word(tx_code_reg, tx_echo_char_field_reg);

    // Release of reset is synchronised; the first stage feeds only the second.
    // It ignores the clock enable, so reset always leaves within two edges.
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_q_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_q_reg <= rst_meta_reg;
        end
    end

    // Transmitter sub-device.
    always @(posedge ref_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            tx_st_reg <= ST_IDLE;
            tx_code_reg <= `STIF_CODE_READY;
            tx_echo_char_field_reg <= `STIF_CHAR_RST;
            tx_control_word_reg <= `STIF_CTRL_RST;
            tx_tmr_reg <= 16'h0000;
            tx_data_reg <= `STIF_CHAR_RST;
            tx_valid_reg <= 1'b0;
            tx_bad_reg <= 1'b0;
            tx_pend_reg <= 1'b0;
        end else if (ce_i) begin
            tx_tmr_reg <= stif_dec(tx_tmr_reg);
            case (tx_st_reg)
                ST_IDLE: begin
                    // Busy writes never reach here, so the running transfer is untouched.
                    if (tx_wr) begin
                        tx_control_word_reg <= wr_data_i;
                        tx_code_reg <= stif_cmd_code(wr_op);
                        if (wr_op == `STIF_OP_RESET) begin
                            tx_echo_char_field_reg <= `STIF_CHAR_RST;
                        end
                        if (tx_start) begin
                            tx_data_reg <= wr_char;
                            tx_valid_reg <= 1'b1;
                            tx_tmr_reg <= TMR_LOAD;
                            tx_st_reg <= ST_XFER;
                            tx_pend_reg <= 1'b0;
                        end else begin
                            tx_pend_reg <= stif_is_illegal(wr_op);
                        end
                    end
                end
                ST_XFER: begin
                    // The error flag only means something beside the accepting ready.
                    if (tx_take) begin
                        tx_valid_reg <= 1'b0;
                        tx_bad_reg <= tx_err_i;
                        tx_st_reg <= ST_PACE;
                    end
                end
                ST_PACE: begin
                    // Completion waits out the character time to cap the rate.
                    if (tx_fin) begin
                        tx_code_reg <= stif_done_code(tx_bad_reg);
                        tx_echo_char_field_reg <= tx_data_reg;
                        tx_pend_reg <= 1'b1;
                        tx_st_reg <= ST_IDLE;
                    end
                end
                default: begin
                    // An unused state code falls back to idle with the link released.
                    tx_st_reg <= ST_IDLE;
                    tx_valid_reg <= 1'b0;
                    tx_tmr_reg <= 16'h0000;
                    tx_bad_reg <= 1'b0;
                end
            endcase
        end
    end

    // Receiver sub-device, fully separate from the transmitter.
    always @(posedge ref_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            rx_st_reg <= ST_IDLE;
            rx_code_reg <= `STIF_CODE_READY;
            rx_char_field_reg <= `STIF_CHAR_RST;
            rx_control_word_reg <= `STIF_CTRL_RST;
            rx_tmr_reg <= 16'h0000;
            rx_hold_reg <= `STIF_CHAR_RST;
            rx_ready_reg <= 1'b0;
            rx_bad_reg <= 1'b0;
            rx_pend_reg <= 1'b0;
        end else if (ce_i) begin
            rx_tmr_reg <= stif_dec(rx_tmr_reg);
            case (rx_st_reg)
                ST_IDLE: begin
                    // A fetch written while busy is dropped, as on the transmitter.
                    if (rx_wr) begin
                        rx_control_word_reg <= {24'h00_0000, wr_op};
                        rx_code_reg <= stif_cmd_code(wr_op);
                        if (wr_op == `STIF_OP_RESET) begin
                            rx_char_field_reg <= `STIF_CHAR_RST;
                        end
                        if (rx_start) begin
                            rx_ready_reg <= 1'b1;
                            rx_tmr_reg <= TMR_LOAD;
                            rx_st_reg <= ST_XFER;
                            rx_pend_reg <= 1'b0;
                        end else begin
                            rx_pend_reg <= stif_is_illegal(wr_op);
                        end
                    end
                end
                ST_XFER: begin
                    // The character waits in the hold register until the character time ends.
                    if (rx_take) begin
                        rx_ready_reg <= 1'b0;
                        rx_hold_reg <= rx_data_i;
                        rx_bad_reg <= rx_err_i;
                        rx_st_reg <= ST_PACE;
                    end
                end
                ST_PACE: begin
                    if (rx_fin) begin
                        rx_code_reg <= stif_done_code(rx_bad_reg);
                        // A failed receive keeps the last good character visible.
                        if (!rx_bad_reg) begin
                            rx_char_field_reg <= rx_hold_reg;
                        end
                        rx_pend_reg <= 1'b1;
                        rx_st_reg <= ST_IDLE;
                    end
                end
                default: begin
                    rx_st_reg <= ST_IDLE;
                    rx_ready_reg <= 1'b0;
                    rx_tmr_reg <= 16'h0000;
                    rx_bad_reg <= 1'b0;
                end
            endcase
        end
    end

    // Register read mux; unmapped addresses, and cycles without a read, give zero.
    // Control words read back as stored; the receiver keeps only its low byte.
    always @* begin
        rd_data_next = 32'h0000_0000;
        if (rd_i) begin
            case (addr_i)
                `STIF_RX_STATE_OFS: rd_data_next = rx_state_word;
                `STIF_RX_CTRL_OFS: rd_data_next = rx_control_word_reg;
                `STIF_TX_STATE_OFS: rd_data_next = tx_state_word;
                `STIF_TX_CTRL_OFS: rd_data_next = tx_control_word_reg;
                `STIF_INT_STAT_OFS: rd_data_next = {28'h000_0000, int_stat};
                `STIF_INT_MASK_OFS: rd_data_next = {28'h000_0000, mask_reg};
                default: rd_data_next = 32'h0000_0000;
            endcase
        end
    end

    // Next values of the interrupt side.
    always @* begin
        evt_next = evt_reg;
        mask_next = mask_reg;
        // A completion in the same cycle as the clearing read survives it.
        if (stat_rd) begin
            evt_next = 2'b00;
        end
        evt_next = evt_next | evt_set;
        if (mask_wr) begin
            mask_next = wr_data_i[3:0];
        end
        // The line drops only once every status bit enabled in mask_reg is clear.
        irq_next = |(int_stat & mask_reg);
    end

    // Bus side, event capture and interrupt line.
    always @(posedge ref_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            evt_reg <= 2'b00;
            mask_reg <= `STIF_MASK_RST;
            irq_reg <= 1'b0;
            rd_data_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            rd_data_reg <= rd_data_next;
            mask_reg <= mask_next;
            evt_reg <= evt_next;
            irq_reg <= irq_next;
        end
    end

    // Every output is a flop with no logic behind it.
    assign rd_data_o = rd_data_reg;
    assign irq_o = irq_reg;
    assign tx_data_o = tx_data_reg;
    assign tx_valid_o = tx_valid_reg;
    assign rx_ready_o = rx_ready_reg;

endmodule // stif_top

// ==== hdl/stif_map.vh ====
// Purpose: Register offsets, field layout, codes and timing of the serial terminal interface.
// Assumes: Included by the terminal interface top module only.
// Notes: Definitions only, no logic.
`ifndef STIF_MAP_VH
`define STIF_MAP_VH

`define STIF_RX_STATE_OFS 8'h00
`define STIF_RX_CTRL_OFS 8'h04
`define STIF_TX_STATE_OFS 8'h08
`define STIF_TX_CTRL_OFS 8'h0c
`define STIF_INT_STAT_OFS 8'h10
`define STIF_INT_MASK_OFS 8'h14

`define STIF_CODE_MSB 7
`define STIF_CODE_LSB 0
`define STIF_CHAR_MSB 15
`define STIF_CHAR_LSB 8

`define STIF_CODE_ABSENT 8'h00
`define STIF_CODE_READY 8'h01
`define STIF_CODE_ILLEGAL 8'h02
`define STIF_CODE_BUSY 8'h03
`define STIF_CODE_ERROR 8'h04
`define STIF_CODE_DONE 8'h05

`define STIF_OP_RESET 8'h00
`define STIF_OP_ACK 8'h01
`define STIF_OP_MOVE 8'h02

`define STIF_CTRL_RST 32'h0000_0000
`define STIF_CHAR_RST 8'h00
`define STIF_MASK_RST 4'h3

`define STIF_CLK_HZ 125000000
`define STIF_CHARS_PER_SEC 12500
// One character time in clocks: 125 MHz over 12500 characters a second.
`define STIF_CHAR_CYCLES 16'h2710

`endif

// ==== test/stif_checker_assertions.sv ====
// Purpose: Port-level checks of the serial terminal interface.
// Assumes: One clock domain; ce_i low freezes the block, so checks pause then.
// Notes: Bound to stif_top below the module.
`timescale 1ns/100ps
module stif_checker #(
    parameter [15:0] CHAR_CYCLES = 16'h2710
) (
    input wire ref_clk_i, // System clock.
    input wire rst_n_i, // Reset, active low.
    input wire ce_i, // Clock enable.
    input wire [7:0] addr_i, // Register address.
    input wire [31:0] wr_data_i, // Write data.
    input wire wr_i, // Write strobe.
    input wire rd_i, // Read strobe.
    input wire [31:0] rd_data_o, // Read data.
    input wire [7:0] tx_data_o, // Character to terminal.
    input wire tx_valid_o, // Character offered.
    input wire tx_ready_i, // Terminal takes it.
    input wire rx_valid_i, // Terminal offers.
    input wire rx_ready_o // Receiver accepts.
);
    logic [15:0] gap_reg;
    logic prv_reg;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i || !ce_i);
    // The gap counter saturates so an idle link never wraps into a false short gap.
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_reg <= 16'hffff;
            prv_reg <= 1'b0;
        end else begin
            prv_reg <= tx_valid_o;
            if (tx_valid_o && !prv_reg) gap_reg <= 16'h0001;
            else if (gap_reg != 16'hffff) gap_reg <= gap_reg + 16'h0001;
        end
    end
    sequence tx_launch_s;
        !tx_valid_o ##1 tx_valid_o;
    endsequence
    sequence rx_launch_s;
        !rx_ready_o ##1 rx_ready_o;
    endsequence
    rd_idle_zero_a: assert property (!$past(rd_i) |-> rd_data_o == 32'h0000_0000)
        else $error("read data not zero outside read answer");
    tx_start_cause_a: assert property (tx_launch_s |-> $past(wr_i) && $past(addr_i) == 8'h0c
        && $past(wr_data_i[7:0]) == 8'h02) else $error("transmit started without send command");
    tx_char_field_a: assert property (tx_launch_s |-> tx_data_o == $past(wr_data_i[15:8]))
        else $error("transmit character not from bits 15..8");
    tx_offer_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("transmit offer dropped or changed");
    tx_one_char_a: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
        else $error("transmit offered more than one character");
    rx_fetch_only_a: assert property (rx_launch_s |-> $past(wr_i) && $past(addr_i) == 8'h04
        && $past(wr_data_i[7:0]) == 8'h02) else $error("receiver ready without fetch command");
    rx_one_char_a: assert property (rx_ready_o && rx_valid_i |=> !rx_ready_o)
        else $error("receiver took more than one character");
    rx_wait_hold_a: assert property (rx_ready_o && !rx_valid_i |=> rx_ready_o)
        else $error("receiver gave up waiting");
    tx_rate_limit_a: assert property (tx_valid_o && !prv_reg |-> gap_reg >= CHAR_CYCLES)
        else $error("transmit rate above limit");
endmodule // stif_checker

bind stif_top stif_checker #(.CHAR_CYCLES(CHAR_CYCLES)) u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .ce_i(ce_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .rx_valid_i(rx_valid_i),
    .rx_ready_o(rx_ready_o));

// ==== test/stif_term_model.sv ====
// Purpose: Behavioural character terminal on the line side.
// Assumes: Bench sets stall, error and character controls.
// Notes: Idle receive data shows the inverse so stale values never pass.
`timescale 1ns/100ps
module stif_term_model (
    input wire clk_i, // Clock.
    input wire rst_n_i, // Reset, active low.
    input wire tx_valid_i, // Offered character.
    input wire [7:0] tx_data_i, // Character.
    output wire tx_ready_o, // Take pulse.
    output wire tx_err_o, // Send error.
    input wire [7:0] wait_i, // Stall cycles.
    input wire tx_bad_i, // Fail the send.
    output wire [7:0] seen_o, // Last taken character.
    input wire rx_on_i, // Offer a character.
    input wire rx_bad_i, // Fail the receive.
    input wire [7:0] rx_char_i, // Character to offer.
    output wire [7:0] rx_data_o, // Receive data.
    output wire rx_valid_o, // Receive offer.
    output wire rx_err_o // Receive error.
);
    logic [7:0] cnt_reg, seen_reg;
    logic rdy_reg;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 8'h00;
            rdy_reg <= 1'b0;
            seen_reg <= 8'h00;
        end else begin
            rdy_reg <= 1'b0;
            if (tx_valid_i && !rdy_reg) begin
                if (cnt_reg == wait_i) begin
                    rdy_reg <= 1'b1;
                    cnt_reg <= 8'h00;
                end else cnt_reg <= cnt_reg + 8'h01;
            end
            if (tx_valid_i && rdy_reg) seen_reg <= tx_data_i;
        end
    end
    assign tx_ready_o = rdy_reg;
    assign tx_err_o = rdy_reg & tx_bad_i;
    assign seen_o = seen_reg;
    assign rx_valid_o = rx_on_i;
    assign rx_data_o = rx_on_i ? rx_char_i : ~rx_char_i;
    assign rx_err_o = rx_on_i & rx_bad_i;
endmodule // stif_term_model

// ==== test/testbench.sv ====
// Purpose: Register-level regression of the serial terminal interface.
// Assumes: CHAR_CYCLES shortened to 20; clock enable dropped once to check the freeze.
// Notes: Completion is found by polling the state word.
`timescale 1ns/100ps
module testbench;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wr_data_i = 32'h0000_0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] wait_c = 8'h00;
    logic [7:0] rx_char = 8'h00;
    logic tx_bad = 1'b0;
    logic rx_bad = 1'b0;
    logic rx_on = 1'b0;
    logic ce_i = 1'b1;
    logic [31:0] d;
    wire [31:0] rd_data_o;
    wire [7:0] tx_data_o, rx_data_i, seen;
    wire irq_o, tx_valid_o, tx_ready_i, tx_err_i, rx_valid_i, rx_err_i, rx_ready_o;
    int fail_count = 0;
    int comparisons = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    stif_top #(.CHAR_CYCLES(16'h0014)) DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .irq_o(irq_o),
        .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_err_i(tx_err_i),
        .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_err_i(rx_err_i), .rx_ready_o(rx_ready_o));
    stif_term_model u_term (.clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
        .tx_ready_o(tx_ready_i), .tx_err_o(tx_err_i), .wait_i(wait_c), .tx_bad_i(tx_bad), .seen_o(seen),
        .rx_on_i(rx_on), .rx_bad_i(rx_bad), .rx_char_i(rx_char), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i),
        .rx_err_o(rx_err_i));
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        addr_i <= a;
        wr_data_i <= v;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 d = rd_data_o;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
        rd(a);
        chk(n, e, d);
    endtask
    // Bounded poll: a stuck busy code ends here and fails the following compare.
    task automatic poll(input logic [7:0] a);
        for (int i = 0; i < 100; i++) begin
            rd(a);
            if (d[7:0] !== 8'h03) break;
        end
    endtask
    // Two edges cover the registered lag of the interrupt output.
    task automatic ck_irq(input logic e);
        repeat (2) @(posedge ref_clk_i);
        #1 chk("irq_o", {31'h0, e}, {31'h0, irq_o});
    endtask
    initial begin
        #200000;
        fail_count++;
        end_sim;
    end
    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        rdc(8'h00, 32'h0000_0001, "rx_state");
        rdc(8'h08, 32'h0000_0001, "tx_state");
        rdc(8'h04, 32'h0000_0000, "rx_ctrl");
        rdc(8'h0c, 32'h0000_0000, "tx_ctrl");
        rdc(8'h14, 32'h0000_0003, "int_mask");
        rdc(8'h20, 32'h0000_0000, "unmapped");
        wr(8'h08, 32'h0000_7705);
        rdc(8'h08, 32'h0000_0001, "tx_state");
        $display("test reset done");
        wait_c <= 8'h05;
        wr(8'h0c, 32'h0000_4102);
        rdc(8'h08, 32'h0000_0003, "tx_state");
        wr(8'h0c, 32'h0000_5502);
        rdc(8'h0c, 32'h0000_4102, "tx_ctrl");
        poll(8'h08);
        chk("tx_state", 32'h0000_4105, d);
        chk("sent_char", 32'h0000_0041, {24'h0, seen});
        ck_irq(1'b1);
        rdc(8'h10, 32'h0000_000a, "int_stat");
        rdc(8'h10, 32'h0000_0002, "int_stat");
        wr(8'h0c, 32'h0000_0001);
        rdc(8'h08, 32'h0000_4101, "tx_state");
        ck_irq(1'b0);
        tx_bad <= 1'b1;
        wait_c <= 8'h00;
        wr(8'h0c, 32'h0000_4202);
        poll(8'h08);
        chk("tx_state", 32'h0000_4204, d);
        tx_bad <= 1'b0;
        wr(8'h0c, 32'h0000_0000);
        rdc(8'h08, 32'h0000_0001, "tx_state");
        $display("test transmit done");
        rx_char <= 8'h5a;
        rx_on <= 1'b1;
        rdc(8'h00, 32'h0000_0001, "rx_state");
        wr(8'h04, 32'h0000_0002);
        rd(8'h00);
        chk("rx_code", 32'h0000_0003, {24'h0, d[7:0]});
        poll(8'h00);
        chk("rx_state", 32'h0000_5a05, d);
        rx_char <= 8'h33;
        rx_bad <= 1'b1;
        wr(8'h04, 32'h0000_0002);
        poll(8'h00);
        chk("rx_state", 32'h0000_5a04, d);
        rx_bad <= 1'b0;
        wr(8'h04, 32'h0000_0000);
        rdc(8'h00, 32'h0000_0001, "rx_state");
        $display("test receive done");
        rx_char <= 8'hc3;
        wait_c <= 8'h03;
        wr(8'h0c, 32'h0000_6602);
        wr(8'h04, 32'h0000_0002);
        poll(8'h08);
        chk("tx_state", 32'h0000_6605, d);
        poll(8'h00);
        chk("rx_state", 32'h0000_c305, d);
        wr(8'h0c, 32'h0000_0001);
        ck_irq(1'b1);
        wr(8'h04, 32'h0000_0001);
        ck_irq(1'b0);
        $display("test concurrent done");
        rx_on <= 1'b0;
        wr(8'h0c, 32'h0000_0007);
        wr(8'h04, 32'h0000_0009);
        rdc(8'h08, 32'h0000_6602, "tx_state");
        rdc(8'h00, 32'h0000_c302, "rx_state");
        ck_irq(1'b1);
        wr(8'h14, 32'h0000_0000);
        ck_irq(1'b0);
        wr(8'h14, 32'h0000_0003);
        ck_irq(1'b1);
        wr(8'h0c, 32'h0000_0001);
        wr(8'h04, 32'h0000_0001);
        ck_irq(1'b0);
        $display("test illegal done");
        ce_i <= 1'b0;
        wr(8'h0c, 32'h0000_7702);
        ce_i <= 1'b1;
        rdc(8'h0c, 32'h0000_0001, "tx_ctrl");
        rdc(8'h08, 32'h0000_6601, "tx_state");
        $display("test freeze done");
        end_sim;
    end
endmodule // testbench
